// file: design/tps_defs.svh
// register offsets, field positions, reset values and write masks of the port control bank
`ifndef TPS_DEFS_SVH
`define TPS_DEFS_SVH
// register indices; byte address is four times the index
`define TPS_IDX_PORT_CFG   16'h6200
`define TPS_IDX_SEG_CTL    16'h6202
`define TPS_IDX_REAS_CTL   16'h6204
`define TPS_IDX_SVC_STAT   16'h6206
// reset values
`define TPS_RST_PORT_CFG   16'h0000
`define TPS_RST_SEG_CTL    16'h0000
`define TPS_RST_REAS_CTL   16'h0000
`define TPS_RST_SVC_STAT   16'h0040
// writable bits, the rest read as zero
`define TPS_WMASK_PORT_CFG 16'he000
`define TPS_WMASK_SEG_CTL  16'he1ff
`define TPS_WMASK_REAS_CTL 16'hfc1f
`define TPS_WMASK_SVC_EN   16'h003e
// port configuration fields
`define TPS_CFG_FMT_MSB    14
`define TPS_CFG_FMT_LSB    13
`define TPS_CFG_LPBK_BIT   15
// segmentation control fields
`define TPS_SEG_BASE_MSB   8
`define TPS_SEG_BASE_LSB   0
`define TPS_SEG_ACT_BIT    13
`define TPS_SEG_INBUF_BIT  14
`define TPS_SEG_XFER_BIT   15
// reassembly control fields
`define TPS_REAS_BASE_MSB  4
`define TPS_REAS_BASE_LSB  0
`define TPS_REAS_REPLAY_BIT 10
`define TPS_REAS_EDGE_BIT  11
`define TPS_REAS_LOS_BIT   12
`define TPS_REAS_ACT_BIT   13
`define TPS_REAS_PIN_BIT   14
`define TPS_REAS_MEM_BIT   15
// service status fields
`define TPS_SVC_EN_LSB     1
`define TPS_SVC_FLAG_LSB   6
`define TPS_SVC_LOS_BIT    6
`define TPS_SVC_CHAN_MSB   15
`define TPS_SVC_CHAN_LSB   11
// flag count and bit count of the last bit of a serial byte
`define TPS_NUM_FLAGS      5
`define TPS_BYTE_LAST      3'h7
`endif

// file: design/tps_pkg.sv
// types shared by the port control bank
package tps_pkg;
  // port data format
  typedef enum logic [1:0] {
    TPS_FMT_OFF     = 2'h0,
    TPS_FMT_UNSTR   = 2'h1,
    TPS_FMT_STR     = 2'h2,
    TPS_FMT_STR_BIG = 2'h3
  } tps_fmt_t;
  // segmentation path requests or grants
  typedef struct packed {
    logic data_valid;
    logic inbuf_wr;
    logic mem_xfer;
  } tps_seg_gate_t;
  // reassembly side events
  typedef struct packed {
    logic       unstr_err;
    logic       str_err;
    logic       perm_under;
    logic       perm_svc_en;
    logic       simple_under;
    logic       simple_svc_en;
    logic [4:0] simple_chan;
  } tps_evt_t;
endpackage

// file: design/tps_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module tps_sync #(
  parameter int W = 3
) (
  input  wire logic         mclk_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  // per bit: three flops and an output flop that follows once stages two and three agree
  genvar g;
  for (g = 0; g < W; g++) begin : g_bit
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic q_r;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
        q_r  <= 1'b0;
      end else if (ce_i) begin
        s1_r <= d_i[g];
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
          q_r <= s3_r;
        end
      end
    end
    assign q_o[g] = q_r;
  end
endmodule // tps_sync

// file: design/tps_regs.sv
// per-port segmentation and reassembly control and status bank with ahb-lite slave
// How it works
// - structured mode: segmentation base field gives ring word address bits 19:11
// - segmentation port inactive blocks all input data onward; active passes it
// - segmentation internal enable gates writes of data and cas into input buffer
// - structured mode: external enable gates input buffer to memory transfers
// - structured mode: reassembly base field gives ring word address bits 19:15
// - structured underrun outputs silence byte when replay select 0, buffer replay when 1
// - output data launched on falling port clock edge at 0, rising at 1
// - unstructured mode drives loss-of-signal output pin with programmed level
// - reassembly port inactive holds output data pin high impedance unless fast loopback set
// - reassembly internal enable gates output buffer moves onto output pin
// - structured mode: reassembly external enable gates memory to output buffer
// - each service enable ands its flag; any result raises service flag
// - loss-of-signal flag sets on incoming pin loss, stays until written 0
// - loss-of-signal flag clear writes ignored until port configuration written
// - separate sticky unstructured and structured output buffer error flags, write 0 clears
// - permanent underrun flag sets only when service enabled and underrun occurs
// - simple underrun flag sets only when service enabled and underrun occurs
// - read-only field holds channel of most recent simple underrun
// - format field picks off, unstructured, structured, or structured over 46 channels
// - fast loopback puts input serial data on output even when port inactive
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "tps_defs.svh"
module tps_regs (
  input  wire logic                   mclk_i,
  input  wire logic                   nrst_i,
  input  wire logic                   ce_i,
  // ahb-lite slave
  input  wire logic                   hsel_i,
  input  wire logic [31:0]            haddr_i,
  input  wire logic [1:0]             htrans_i,
  input  wire logic                   hwrite_i,
  input  wire logic [2:0]             hsize_i,
  input  wire logic [31:0]            hwdata_i,
  input  wire logic                   hready_i,
  output logic      [31:0]            hrdata_o,
  output logic                        hreadyout_o,
  output logic                        hresp_o,
  // segmentation path
  input  wire tps_pkg::tps_seg_gate_t seg_req_i,
  output tps_pkg::tps_seg_gate_t      seg_grant_o,
  output logic      [8:0]             seg_ring_base_o,
  // reassembly path
  input  wire logic                   reas_mem_req_i,
  output logic                        reas_mem_xfer_o,
  output logic      [4:0]             reas_ring_base_o,
  input  wire logic [7:0]             buf_byte_i,
  input  wire logic [7:0]             silence_byte_i,
  input  wire logic                   underrun_i,
  output logic                        byte_take_o,
  input  wire tps_pkg::tps_evt_t      evt_i,
  // pins
  input  wire logic                   port_out_clock_i,
  input  wire logic                   serial_data_in_i,
  input  wire logic                   los_in_pin_i,
  output logic                        serial_data_out_o,
  output logic                        serial_data_out_oe_o,
  output logic                        los_out_pin_o,
  output logic                        tdm_service_flag_o
);
  import tps_pkg::*;

  logic [15:0] port_cfg_r;
  logic [15:0] seg_ctl_r;
  logic [15:0] reas_ctl_r;
  logic [4:0]  svc_en_r;
  logic [4:0]  flag_r;
  logic [4:0]  flag_nxt;
  logic [4:0]  flag_set;
  logic [4:0]  chan_r;
  logic        cfg_programmed_r;
  logic        wr_pend_r;
  logic        rd_pend_r;
  logic        rd_wait_done_r;
  logic [15:0] idx_r;
  logic        idx_hit_r;
  logic [31:0] hrdata_r;
  logic [15:0] rd_mux;
  logic        addr_phase;
  logic        wr_cfg;
  logic        wr_seg;
  logic        wr_reas;
  logic        wr_svc;
  logic [15:0] wdata;
  tps_fmt_t    fmt;
  logic        str_mode;
  logic        unstr_mode;
  logic        lpbk;
  logic [2:0]  pins_s;
  logic        clk_s;
  logic        din_s;
  logic        los_s;
  logic        clk_prev_r;
  logic        launch;
  logic [7:0]  shift_r;
  logic [2:0]  bit_cnt_r;
  logic        sdo_r;
  logic        byte_take_r;
  logic        los_out_r;
  logic [7:0]  next_byte;

  // pin inputs through the three-stage filter
  tps_sync #(.W(3)) u_sync (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .ce_i   (ce_i),
    .d_i    ({port_out_clock_i, serial_data_in_i, los_in_pin_i}),
    .q_o    (pins_s)
  );
  assign clk_s = pins_s[2];
  assign din_s = pins_s[1];
  assign los_s = pins_s[0];

  // mode decode
  assign fmt        = tps_fmt_t'(port_cfg_r[`TPS_CFG_FMT_MSB:`TPS_CFG_FMT_LSB]);
  assign unstr_mode = (fmt == TPS_FMT_UNSTR);
  assign str_mode   = (fmt == TPS_FMT_STR) || (fmt == TPS_FMT_STR_BIG);
  assign lpbk       = port_cfg_r[`TPS_CFG_LPBK_BIT];

  // bus address phase and write strobes
  assign addr_phase = hsel_i && htrans_i[1] && hready_i;
  assign wdata      = hwdata_i[15:0];
  assign wr_cfg     = wr_pend_r && idx_hit_r && (idx_r == `TPS_IDX_PORT_CFG);
  assign wr_seg     = wr_pend_r && idx_hit_r && (idx_r == `TPS_IDX_SEG_CTL);
  assign wr_reas    = wr_pend_r && idx_hit_r && (idx_r == `TPS_IDX_REAS_CTL);
  assign wr_svc     = wr_pend_r && idx_hit_r && (idx_r == `TPS_IDX_SVC_STAT);

  // capture address phase; reads take one wait state
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      idx_r     <= 16'h0000;
      idx_hit_r <= 1'b0;
    end else if (ce_i) begin
      if (addr_phase) begin
        wr_pend_r <= hwrite_i;
        rd_pend_r <= !hwrite_i;
        idx_r     <= haddr_i[17:2];
        idx_hit_r <= (haddr_i[31:18] == 14'h0000) && (haddr_i[1:0] == 2'h0);
      end else if (hreadyout_o) begin
        wr_pend_r <= 1'b0;
        rd_pend_r <= 1'b0;
      end else begin
        rd_pend_r <= 1'b0;
      end
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    rd_mux = 16'h0000;
    if (idx_hit_r) begin
      unique case (idx_r)
        `TPS_IDX_PORT_CFG: rd_mux = port_cfg_r;
        `TPS_IDX_SEG_CTL:  rd_mux = seg_ctl_r;
        `TPS_IDX_REAS_CTL: rd_mux = reas_ctl_r;
        `TPS_IDX_SVC_STAT: rd_mux = {chan_r, flag_r, svc_en_r, 1'b0};
        default:           rd_mux = 16'h0000;
      endcase
    end
  end

  // read data latched in the wait state
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hrdata_r <= 32'h0000_0000;
    end else if (ce_i && rd_pend_r && !hreadyout_o) begin
      hrdata_r <= {16'h0000, rd_mux};
    end
  end
  assign hrdata_o    = hrdata_r;
  assign hreadyout_o = !(rd_pend_r && !rd_wait_done_r); // low only in first read data cycle
  assign hresp_o     = 1'b0;

  // wait state lasts one cycle after the address phase of a read
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_wait_done_r <= 1'b0;
    end else if (ce_i) begin
      rd_wait_done_r <= rd_pend_r && !rd_wait_done_r;
    end
  end

  // control registers
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      port_cfg_r       <= `TPS_RST_PORT_CFG;
      seg_ctl_r        <= `TPS_RST_SEG_CTL;
      reas_ctl_r       <= `TPS_RST_REAS_CTL;
      svc_en_r         <= 5'h00;
      cfg_programmed_r <= 1'b0;
    end else if (ce_i) begin
      if (wr_cfg) begin
        port_cfg_r       <= wdata & `TPS_WMASK_PORT_CFG;
        cfg_programmed_r <= 1'b1;
      end
      if (wr_seg) begin
        seg_ctl_r <= wdata & `TPS_WMASK_SEG_CTL;
      end
      if (wr_reas) begin
        reas_ctl_r <= wdata & `TPS_WMASK_REAS_CTL;
      end
      if (wr_svc) begin
        svc_en_r <= wdata[5:1];
      end
    end
  end

  // event sources of the five sticky flags
  assign flag_set[0] = los_s;
  assign flag_set[1] = evt_i.unstr_err;
  assign flag_set[2] = evt_i.str_err;
  assign flag_set[3] = evt_i.perm_under && evt_i.perm_svc_en;
  assign flag_set[4] = evt_i.simple_under && evt_i.simple_svc_en;

  // per flag: set wins, write 0 clears (flag 0 only once port configuration written), write 1 keeps
  genvar f;
  for (f = 0; f < `TPS_NUM_FLAGS; f++) begin : g_flag
    logic clr;
    assign clr = wr_svc && !wdata[`TPS_SVC_FLAG_LSB + f] && ((f != 0) || cfg_programmed_r);
    assign flag_nxt[f] = flag_set[f] || (flag_r[f] && !clr);
  end

  // flag and channel storage
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_r <= 5'(`TPS_RST_SVC_STAT >> `TPS_SVC_FLAG_LSB);
      chan_r <= 5'h00;
    end else if (ce_i) begin
      flag_r <= flag_nxt;
      if (evt_i.simple_under) begin
        chan_r <= evt_i.simple_chan;
      end
    end
  end
  assign tdm_service_flag_o = |(flag_r & svc_en_r);

  // segmentation gating
  assign seg_grant_o.data_valid = seg_req_i.data_valid && seg_ctl_r[`TPS_SEG_ACT_BIT];
  assign seg_grant_o.inbuf_wr   = seg_req_i.inbuf_wr && seg_ctl_r[`TPS_SEG_INBUF_BIT];
  assign seg_grant_o.mem_xfer   = seg_req_i.mem_xfer && seg_ctl_r[`TPS_SEG_XFER_BIT] && str_mode;
  assign seg_ring_base_o        = seg_ctl_r[`TPS_SEG_BASE_MSB:`TPS_SEG_BASE_LSB];
  // reassembly memory side
  assign reas_mem_xfer_o  = reas_mem_req_i && reas_ctl_r[`TPS_REAS_MEM_BIT] && str_mode;
  assign reas_ring_base_o = reas_ctl_r[`TPS_REAS_BASE_MSB:`TPS_REAS_BASE_LSB];

  // launch edge chosen by the edge bit
  assign launch = reas_ctl_r[`TPS_REAS_EDGE_BIT] ? (clk_s && !clk_prev_r) : (!clk_s && clk_prev_r);
  // silence only in structured underrun with replay off
  assign next_byte = (underrun_i && str_mode && !reas_ctl_r[`TPS_REAS_REPLAY_BIT]) ? silence_byte_i
                                                                                 : buf_byte_i;

  // serial output shifter and loopback
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clk_prev_r  <= 1'b0;
      shift_r     <= 8'h00;
      bit_cnt_r   <= 3'h0;
      sdo_r       <= 1'b0;
      byte_take_r <= 1'b0;
    end else if (ce_i) begin
      clk_prev_r  <= clk_s;
      byte_take_r <= 1'b0;
      if (launch) begin
        if (lpbk) begin
          sdo_r <= din_s;
        end else if (reas_ctl_r[`TPS_REAS_PIN_BIT]) begin
          sdo_r     <= shift_r[7];
          bit_cnt_r <= bit_cnt_r + 3'h1;
          if (bit_cnt_r == `TPS_BYTE_LAST) begin
            shift_r     <= next_byte;
            byte_take_r <= 1'b1;
          end else begin
            shift_r <= {shift_r[6:0], 1'b0};
          end
        end
      end
    end
  end
  assign serial_data_out_o    = sdo_r;
  assign byte_take_o          = byte_take_r;
  assign serial_data_out_oe_o = reas_ctl_r[`TPS_REAS_ACT_BIT] || lpbk;

  // outgoing loss-of-signal pin
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      los_out_r <= 1'b0;
    end else if (ce_i) begin
      los_out_r <= unstr_mode && reas_ctl_r[`TPS_REAS_LOS_BIT];
    end
  end
  assign los_out_pin_o = los_out_r;

  // checks
  property p_seg_pass;
    @(posedge mclk_i) disable iff (!nrst_i)
      seg_grant_o.data_valid |-> (seg_req_i.data_valid && seg_ctl_r[`TPS_SEG_ACT_BIT]);
  endproperty
  a_seg_pass: assert property (p_seg_pass) else $error("input data passed while port inactive");

  property p_seg_xfer;
    @(posedge mclk_i) disable iff (!nrst_i)
      seg_grant_o.mem_xfer |-> (str_mode && seg_ctl_r[`TPS_SEG_XFER_BIT]);
  endproperty
  a_seg_xfer: assert property (p_seg_xfer) else $error("memory transfer outside enabled structured mode");

  property p_oe;
    @(posedge mclk_i) disable iff (!nrst_i)
      !reas_ctl_r[`TPS_REAS_ACT_BIT] && !lpbk |-> !serial_data_out_oe_o;
  endproperty
  a_oe: assert property (p_oe) else $error("output driven while port inactive");

  property p_service;
    @(posedge mclk_i) disable iff (!nrst_i)
      (flag_r[2] && svc_en_r[2]) |-> tdm_service_flag_o;
  endproperty
  a_service: assert property (p_service) else $error("enabled flag did not raise service");

  property p_los_set;
    @(posedge mclk_i) disable iff (!nrst_i)
      (ce_i && los_s) |=> flag_r[0];
  endproperty
  a_los_set: assert property (p_los_set) else $error("loss flag not set");

  sequence s_early_clear;
    ce_i && wr_svc && !wdata[`TPS_SVC_LOS_BIT] && !cfg_programmed_r && flag_r[0];
  endsequence
  property p_los_hold;
    @(posedge mclk_i) disable iff (!nrst_i)
      s_early_clear |=> flag_r[0];
  endproperty
  a_los_hold: assert property (p_los_hold) else $error("loss flag cleared before configuration");

  property p_str_err;
    @(posedge mclk_i) disable iff (!nrst_i)
      (ce_i && evt_i.str_err) |=> flag_r[2] ##1 (flag_r[2] || $past(wr_svc));
  endproperty
  a_str_err: assert property (p_str_err) else $error("structured buffer error not latched");

  property p_simple_gate;
    @(posedge mclk_i) disable iff (!nrst_i)
      (ce_i && !flag_r[4] && !evt_i.simple_svc_en) |=> !flag_r[4];
  endproperty
  a_simple_gate: assert property (p_simple_gate) else $error("simple underrun set without enable");

  sequence s_simple_evt;
    ce_i && evt_i.simple_under;
  endsequence
  property p_chan;
    @(posedge mclk_i) disable iff (!nrst_i)
      s_simple_evt |=> (chan_r == $past(evt_i.simple_chan));
  endproperty
  a_chan: assert property (p_chan) else $error("underrun channel not recorded");

  property p_keep_ones;
    @(posedge mclk_i) disable iff (!nrst_i)
      (ce_i && wr_svc && wdata[`TPS_SVC_FLAG_LSB + 1] && flag_r[1]) |=> flag_r[1];
  endproperty
  a_keep_ones: assert property (p_keep_ones) else $error("writing one disturbed a flag");

  property p_los_out;
    @(posedge mclk_i) disable iff (!nrst_i)
      (ce_i && unstr_mode) |=> (los_out_pin_o == $past(reas_ctl_r[`TPS_REAS_LOS_BIT]));
  endproperty
  a_los_out: assert property (p_los_out) else $error("loss output not following level");
endmodule // tps_regs

// file: verif/tps_framer_model.sv
// framer side model: port clock, serial input, loss pin and output capture
`timescale 1ns/1ps
module tps_framer_model (
  input  wire logic        run_i,
  input  wire logic        edge_i,
  input  wire logic        sdi_val_i,
  input  wire logic        los_i,
  input  wire logic        sdo_i,
  input  wire logic        oe_i,
  output logic             port_out_clock_o,
  output logic             serial_data_in_o,
  output logic             los_in_pin_o,
  output logic [7:0]       cap_o,
  output logic [15:0]      launches_o
);
  logic line;
  // released output line is pulled high
  assign line = oe_i ? sdo_i : 1'b1;
  assign serial_data_in_o = sdi_val_i;
  assign los_in_pin_o = los_i;
  initial begin
    port_out_clock_o = 1'b0;
    cap_o = 8'h00;
    launches_o = 16'h0000;
  end
  // clock stands still outside frames; capture on the edge opposite the launch
  always begin
    wait (run_i);
    #100;
    port_out_clock_o = ~port_out_clock_o;
    if (port_out_clock_o == !edge_i)
      cap_o = {cap_o[6:0], line};
    else
      launches_o = launches_o + 16'h0001;
  end
endmodule // tps_framer_model

// file: verif/tps_regs_tb_top.sv
// self-checking bench for the port control bank
`timescale 1ns/1ps
`include "tps_defs.svh"
module tps_regs_tb_top;
  import tps_pkg::*;
  logic          mclk_i, nrst_i, hsel, hwrite, hready, hresp;
  logic [31:0]   haddr, hwdata, hrdata, rd;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  tps_seg_gate_t seg_req, seg_grant;
  tps_evt_t      evt;
  logic [8:0]    seg_base;
  logic [4:0]    reas_base, c1, c2;
  logic [7:0]    buf_byte, sil_byte, cap;
  logic [15:0]   launches, s, r, c;
  logic          reas_req, reas_xfer, underrun, take, pclk, sdi, los_in, sdo, oe, los_out, srv;
  logic          run, edge_sel, sdi_val, los_val;
  int            err_total, tests_run, seed, takes;

  tps_regs tps_regs_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(1'b1), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .seg_req_i(seg_req), .seg_grant_o(seg_grant),
    .seg_ring_base_o(seg_base), .reas_mem_req_i(reas_req), .reas_mem_xfer_o(reas_xfer),
    .reas_ring_base_o(reas_base), .buf_byte_i(buf_byte), .silence_byte_i(sil_byte), .underrun_i(underrun),
    .byte_take_o(take), .evt_i(evt), .port_out_clock_i(pclk), .serial_data_in_i(sdi), .los_in_pin_i(los_in),
    .serial_data_out_o(sdo), .serial_data_out_oe_o(oe), .los_out_pin_o(los_out), .tdm_service_flag_o(srv));

  tps_framer_model tps_framer_model_inst (.run_i(run), .edge_i(edge_sel), .sdi_val_i(sdi_val),
    .los_i(los_val), .sdo_i(sdo), .oe_i(oe), .port_out_clock_o(pclk), .serial_data_in_o(sdi),
    .los_in_pin_o(los_in), .cap_o(cap), .launches_o(launches));

  // clock and byte load counter
  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (take === 1'b1) takes++;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one ahb-lite single transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    logic rdy;
    htrans <= 2'h2;
    haddr <= {14'h0, idx, 2'b00};
    hwrite <= wr;
    hsize <= 3'h2;
    do begin
      @(negedge mclk_i) rdy = hready;
      @(posedge mclk_i);
    end while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(negedge mclk_i) rdy = hready;
      rd = hrdata;
      @(posedge mclk_i);
    end while (rdy !== 1'b1);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    bus(1'b1, idx, {16'h0, d});
  endtask

  task automatic rdchk(input logic [15:0] idx, input logic [15:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, {16'h0, exp});
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic pulse(input tps_evt_t e);
    evt <= e;
    @(posedge mclk_i);
    evt <= '0;
    @(posedge mclk_i);
  endtask

  // run the port clock for three bytes and compare the captured byte
  task automatic ser(input logic [15:0] cv, input logic [15:0] rv, input logic [7:0] exp);
    logic [15:0] l0;
    wr(`TPS_IDX_PORT_CFG, cv);
    wr(`TPS_IDX_REAS_CTL, rv);
    edge_sel <= rv[11];
    run <= 1'b1;
    takes = 0;
    l0 = launches;
    while (launches < l0 + 16'd24) @(posedge mclk_i);
    run <= 1'b0;
    chk({24'h0, cap}, {24'h0, exp});
    if (rv[14]) chk({31'h0, takes >= 2 && takes <= 4}, 32'h1);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    end_sim;
  end

  initial begin
    seed = 32'h74b7aa09;
    mclk_i = 1'b0;
    nrst_i = 1'b0;
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {seg_req, reas_req, evt, underrun, run, edge_sel, sdi_val, los_val} = '0;
    buf_byte = 8'h00;
    sil_byte = 8'hff;
    repeat (2) @(posedge mclk_i);
    nrst_i <= 1'b1;
    hsel <= 1'b1;
    @(posedge mclk_i);
    // reset values and unmapped place
    rdchk(`TPS_IDX_PORT_CFG, `TPS_RST_PORT_CFG);
    rdchk(`TPS_IDX_SEG_CTL, `TPS_RST_SEG_CTL);
    rdchk(`TPS_IDX_REAS_CTL, `TPS_RST_REAS_CTL);
    rdchk(`TPS_IDX_SVC_STAT, `TPS_RST_SVC_STAT);
    chk({30'h0, oe, srv}, 32'h0);
    wr(16'h6208, 16'hffff);
    rdchk(16'h6208, 16'h0000);
    // loss flag clear ignored until port configuration written
    wr(`TPS_IDX_SVC_STAT, 16'h0000);
    rdchk(`TPS_IDX_SVC_STAT, 16'h0040);
    wr(`TPS_IDX_SVC_STAT, 16'h003e);
    rdchk(`TPS_IDX_SVC_STAT, 16'h007e);
    chk({31'h0, srv}, 32'h1);
    wr(`TPS_IDX_PORT_CFG, 16'h2000);
    wr(`TPS_IDX_SVC_STAT, 16'h003e);
    rdchk(`TPS_IDX_SVC_STAT, 16'h003e);
    chk({31'h0, srv}, 32'h0);
    // events: gated underruns, then all four event flags
    c1 = 5'($random(seed));
    c2 = 5'($random(seed));
    pulse({6'b001010, c1});
    rdchk(`TPS_IDX_SVC_STAT, {c1, 11'h03e});
    pulse({6'b111111, c2});
    rdchk(`TPS_IDX_SVC_STAT, {c2, 11'h7be});
    wr(`TPS_IDX_SVC_STAT, 16'hffbe);
    rdchk(`TPS_IDX_SVC_STAT, {c2, 11'h7be});
    wr(`TPS_IDX_SVC_STAT, 16'h073e);
    rdchk(`TPS_IDX_SVC_STAT, {c2, 11'h73e});
    wr(`TPS_IDX_SVC_STAT, 16'h0700);
    @(posedge mclk_i);
    chk({31'h0, srv}, 32'h0);
    wr(`TPS_IDX_SVC_STAT, 16'h0720);
    @(posedge mclk_i);
    chk({31'h0, srv}, 32'h1);
    los_val <= 1'b1;
    repeat (10) @(posedge mclk_i);
    rdchk(`TPS_IDX_SVC_STAT, {c2, 11'h760});
    los_val <= 1'b0;
    // random control values against gates, bases and pins
    for (int i = 0; i < 8; i++) begin
      s = 16'($random(seed));
      r = 16'($random(seed));
      c = 16'($random(seed)) & 16'h6000;
      seg_req <= 3'($random(seed));
      reas_req <= 1'($random(seed));
      wr(`TPS_IDX_PORT_CFG, c);
      wr(`TPS_IDX_SEG_CTL, s);
      wr(`TPS_IDX_REAS_CTL, r);
      rdchk(`TPS_IDX_PORT_CFG, c & `TPS_WMASK_PORT_CFG);
      rdchk(`TPS_IDX_SEG_CTL, s & `TPS_WMASK_SEG_CTL);
      rdchk(`TPS_IDX_REAS_CTL, r & `TPS_WMASK_REAS_CTL);
      chk({29'h0, seg_grant}, {29'h0, seg_req[2] & s[13], seg_req[1] & s[14], seg_req[0] & s[15] & c[14]});
      chk({31'h0, reas_xfer}, {31'h0, reas_req & r[15] & c[14]});
      chk({23'h0, seg_base}, {23'h0, s[8:0]});
      chk({27'h0, reas_base}, {27'h0, r[4:0]});
      chk({31'h0, los_out}, {31'h0, c[14:13] == 2'b01 && r[12]});
      chk({31'h0, oe}, {31'h0, r[13]});
    end
    // underrun silence or replay on either launch edge; port never in backplane bus format
    underrun <= 1'b1;
    for (int k = 0; k < 4; k++) ser(16'h4000, 16'h6000 | 16'(k) << 10, k[0] ? 8'h00 : 8'hff);
    ser(16'h2000, 16'h6000, 8'h00);
    // loopback with the reassembly port inactive
    for (int b = 0; b < 2; b++) begin
      sdi_val <= b[0];
      ser(16'hc000, 16'h0000, {8{b[0]}});
      chk({31'h0, oe}, 32'h1);
    end
    end_sim;
  end
endmodule // tps_regs_tb_top
